// ==== common/port_pin_map.vh ====
// Purpose: register offsets, field positions and reset values of the port pin block
// Assumes: AHB-Lite word registers, byte addresses
// Notes:   definitions only
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH

`define OFS_PORT_DATA      8'h00
`define OFS_PORT_LATCH     8'h04
`define OFS_DIRECTION      8'h08
`define OFS_ANALOG_SELECT  8'h0C
`define OFS_PULLUP_ENABLE  8'h10
`define OFS_OPTION         8'h14
`define OFS_CHANGE_ENABLE  8'h18
`define OFS_INTERRUPT_CTRL 8'h1C
`define OFS_STATUS         8'h20

`define BIT_GLOBAL_PULLUP_DISABLE 7
`define BIT_PORT_CHANGE_FLAG      0
`define BIT_MASTER_CLEAR_MODE     0
`define BIT_SLEEPING              1

`define RST_DIRECTION      8'hFF
`define RST_ANALOG_SELECT  8'hFF
`define RST_PULLUP_ENABLE  8'hFF
`define RST_OPTION         8'hFF
`define RST_CHANGE_ENABLE  8'h00
`define RST_LATCH          8'h00

`endif

// ==== rtl/pin_sync.v ====
// Purpose: two-stage synchroniser for a bus of pin levels
// Assumes: pins asynchronous to clk_i
// Notes:   first stage read only by the second
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/port_pin_pullup_change_detect.v ====
// Purpose: first port pin logic: analog gating, weak pull-ups, change detect
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   pin three doubles as master clear pin
// Contract
// - analog-selected pin reads as zero
// - analog select leaves output drive untouched
// - per-pin pull-up enable except pin three
// - output direction forces pull-up off, except on pin three
// - power-on sets global pull-up disable
// - pin three pull-up follows master clear
// - change enables cleared on power-on
// - enabled mismatches ORed into change flag
// - change flag wakes core from sleep
// - persisting mismatch keeps setting flag
// - last-read latch survives master clear, brownout
// - change coinciding with read still sets flag in the same cycle
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_map.vh"

module port_pin_pullup_change_detect #(
  parameter WIDTH            = 8,
  parameter MASTER_CLEAR_PIN = 3
) (
  input  wire             clk_i,
  input  wire             resetn_i,
  input  wire             por_n_i,
  input  wire             hsel_i,
  input  wire [31:0]      haddr_i,
  input  wire [1:0]       htrans_i,
  input  wire             hwrite_i,
  input  wire [2:0]       hsize_i,
  input  wire [31:0]      hwdata_i,
  input  wire             hready_i,
  output reg  [31:0]      hrdata_o,
  output reg              hreadyout_o,
  output reg              hresp_o,
  input  wire [WIDTH-1:0] pin_i,
  output reg  [WIDTH-1:0] pin_o,
  output reg  [WIDTH-1:0] pin_oe_o,
  output reg  [WIDTH-1:0] pullup_on_o,
  output reg              port_change_flag_o,
  output reg              wake_o
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rst_s1;
  reg rst_n;
  reg por_s1;
  reg por_n;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always @(posedge clk_i or negedge por_n_i)
  begin
    if (!por_n_i)
    begin
      por_s1 <= 1'b0;
      por_n  <= 1'b0;
    end
    else
    begin
      por_s1 <= 1'b1;
      por_n  <= por_s1;
    end
  end

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  wire [WIDTH-1:0] pin_sync;

  pin_sync #(
    .WIDTH (WIDTH)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  );

  // ------------------------------------------------------------
  // bus address phase capture
  // ------------------------------------------------------------
  reg       dp_valid;
  reg       dp_write;
  reg [7:0] dp_addr;

  // zero wait states: every address phase is taken at once
  wire take = hsel_i & htrans_i[1] & hready_i;

  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else
    begin
      dp_valid <= take;
      dp_write <= hwrite_i;
      dp_addr  <= haddr_i[7:0];
    end
  end

  wire wr = dp_valid & dp_write;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  reg [WIDTH-1:0] out_latch;
  reg [WIDTH-1:0] direction;
  reg [WIDTH-1:0] analog_select;
  reg [WIDTH-1:0] pullup_enable;
  reg [7:0]       option_reg;
  reg [WIDTH-1:0] change_enable;
  reg             master_clear_mode;
  reg             sleeping;

  // power-on-only state
  always @(posedge clk_i or negedge por_n)
  begin
    if (!por_n)
    begin
      option_reg        <= `RST_OPTION;
      change_enable     <= `RST_CHANGE_ENABLE;
      master_clear_mode <= 1'b1;
    end
    else if (wr)
    begin
      case (dp_addr)
        `OFS_OPTION:        option_reg <= hwdata_i[7:0];
        `OFS_CHANGE_ENABLE: change_enable <= hwdata_i[WIDTH-1:0];
        `OFS_STATUS:        master_clear_mode <= hwdata_i[`BIT_MASTER_CLEAR_MODE];
        default:            option_reg <= option_reg;
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_latch     <= {WIDTH{1'b0}};
      direction     <= {WIDTH{1'b1}};
      analog_select <= {WIDTH{1'b1}};
      pullup_enable <= {WIDTH{1'b1}};
      sleeping      <= 1'b0;
    end
    else
    begin
      if (wr)
      begin
        case (dp_addr)
          `OFS_PORT_DATA:     out_latch <= hwdata_i[WIDTH-1:0];
          `OFS_PORT_LATCH:    out_latch <= hwdata_i[WIDTH-1:0];
          `OFS_DIRECTION:     direction <= hwdata_i[WIDTH-1:0];
          `OFS_ANALOG_SELECT: analog_select <= hwdata_i[WIDTH-1:0];
          `OFS_PULLUP_ENABLE: pullup_enable <= hwdata_i[WIDTH-1:0];
          default:            out_latch <= out_latch;
        endcase
      end
      if (wr && dp_addr == `OFS_STATUS && hwdata_i[`BIT_SLEEPING])
        sleeping <= 1'b1;
      else if (port_change_flag_o)
        sleeping <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin read value and last-read latch
  // ------------------------------------------------------------
  wire [WIDTH-1:0] pin_read = pin_sync & ~analog_select;
  wire             port_access = dp_valid && dp_addr == `OFS_PORT_DATA;
  reg  [WIDTH-1:0] last_read;

  // kept through master clear and brownout: power-on only
  always @(posedge clk_i or negedge por_n)
  begin
    if (!por_n)
      last_read <= `RST_LATCH;
    else if (port_access)
      last_read <= pin_read;
  end

  // ------------------------------------------------------------
  // change flag
  // ------------------------------------------------------------
  wire [WIDTH-1:0] mismatch = (pin_read ^ last_read) & change_enable;
  wire             any_mismatch = |mismatch;
  wire             flag_clear = wr && dp_addr == `OFS_INTERRUPT_CTRL &&
                                !hwdata_i[`BIT_PORT_CHANGE_FLAG];
  wire             flag_set = wr && dp_addr == `OFS_INTERRUPT_CTRL &&
                              hwdata_i[`BIT_PORT_CHANGE_FLAG];
  reg              next_flag;

  // a set in the clear cycle wins, so a live mismatch survives

  always @*
  begin
    next_flag = port_change_flag_o;
    if (flag_clear)
      next_flag = 1'b0;
    if (flag_set || any_mismatch)
      next_flag = 1'b1;
  end

  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      port_change_flag_o <= 1'b0;
    else
      port_change_flag_o <= next_flag;
  end

  // ------------------------------------------------------------
  // pin drive and pull-ups
  // ------------------------------------------------------------
  // pin three pull-up follows master_clear_mode only, no pull-up enable bit
  reg [WIDTH-1:0] next_pullup;
  integer i;

  always @*
  begin
    next_pullup = {WIDTH{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1)
    begin
      if (i == MASTER_CLEAR_PIN)
        next_pullup[i] = master_clear_mode;
      else
        next_pullup[i] = pullup_enable[i] & direction[i] &
                         ~option_reg[`BIT_GLOBAL_PULLUP_DISABLE];
    end
  end

  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_o       <= {WIDTH{1'b0}};
      pin_oe_o    <= {WIDTH{1'b0}};
      pullup_on_o <= {WIDTH{1'b0}};
      wake_o      <= 1'b0;
    end
    else
    begin
      pin_o       <= out_latch;
      pin_oe_o    <= ~direction;
      pullup_on_o <= next_pullup;
      wake_o      <= sleeping & port_change_flag_o;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // launched at the address phase, stands through the data phase
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (haddr_i[7:0])
      `OFS_PORT_DATA:      next_rdata[WIDTH-1:0] = pin_read;
      `OFS_PORT_LATCH:     next_rdata[WIDTH-1:0] = out_latch;
      `OFS_DIRECTION:      next_rdata[WIDTH-1:0] = direction;
      `OFS_ANALOG_SELECT:  next_rdata[WIDTH-1:0] = analog_select;
      `OFS_PULLUP_ENABLE:  next_rdata[WIDTH-1:0] = pullup_enable;
      `OFS_OPTION:         next_rdata[7:0] = option_reg;
      `OFS_CHANGE_ENABLE:  next_rdata[WIDTH-1:0] = change_enable;
      `OFS_INTERRUPT_CTRL: next_rdata[`BIT_PORT_CHANGE_FLAG] = port_change_flag_o;
      `OFS_STATUS:         next_rdata[1:0] = {sleeping, master_clear_mode};
      default:             next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (take && !hwrite_i)
        hrdata_o <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ==== verif/pin_partner.sv ====
// Purpose: external circuitry on the port pins
// Assumes: device drive wins over external drive
// Notes:   undriven pins without pull-up float to a toggling level
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input  wire logic [7:0] drive_i,
  input  wire logic       clk_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic [7:0]      level_o
);
  logic [7:0] flt = 8'h00;
  always @(posedge clk_i)
    flt <= ~flt;
  assign level_o = (oe_i & drive_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pullup_i | flt));
endmodule
`default_nettype wire

// ==== verif/port_pin_chk.sv ====
// Purpose: bus and pin output checks of the port pin block
// Assumes: pin outputs move three edges after a write's address phase
// Notes:   bound to the top module
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_map.vh"
module port_pin_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  pullup_on_o,
  input wire logic        port_change_flag_o,
  input wire logic        wake_o
);
  logic [5:0]       rs;
  wire logic [7:0]  a = haddr_i[7:0];
  wire logic        rd = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  wire logic        wr = hsel_i & htrans_i[1] & hready_i & hwrite_i;
  wire logic        w_ic = wr & (a == `OFS_INTERRUPT_CTRL);
  wire logic        w_out = wr & (a == `OFS_PORT_DATA | a == `OFS_PORT_LATCH);
  wire logic        w_dir = wr & (a == `OFS_DIRECTION);
  wire logic        w_pu = w_dir | wr & (a == `OFS_PULLUP_ENABLE | a == `OFS_OPTION | a == `OFS_STATUS);
  // settle window after reset release
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      rs <= 6'h00;
    else
      rs <= {rs[4:0], 1'b1};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rs[5]);
  property p_okay; hreadyout_o && !hresp_o; endproperty
  a_okay: assert property (p_okay) else $error("slave not ready or not okay");
  property p_pu_out; (pullup_on_o & pin_oe_o & 8'hF7) == 8'h00; endproperty
  a_pu_out: assert property (p_pu_out) else $error("pull-up on at output pin");
  property p_wake; wake_o |-> port_change_flag_o || $past(port_change_flag_o); endproperty
  a_wake: assert property (p_wake) else $error("wake without change flag");
  property p_flag; $fell(port_change_flag_o) |-> $past(w_ic, 2); endproperty
  a_flag: assert property (p_flag) else $error("change flag fell without clear");
  property p_out; !$stable(pin_o) |-> $past(w_out, 3); endproperty
  a_out: assert property (p_out) else $error("output value moved without write");
  property p_dir; !$stable(pin_oe_o) |-> $past(w_dir, 3); endproperty
  a_dir: assert property (p_dir) else $error("drive enable moved without write");
  property p_pu; !$stable(pullup_on_o) |-> $past(w_pu, 3); endproperty
  a_pu: assert property (p_pu) else $error("pull-up moved without write");
  property p_rdata; !$stable(hrdata_o) |-> $past(rd); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without read");
endmodule
bind port_pin_pullup_change_detect port_pin_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .pullup_on_o(pullup_on_o), .port_change_flag_o(port_change_flag_o), .wake_o(wake_o));
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the port pin block
// Assumes: zero wait slave, pins reach the change logic within four edges
// Notes:   random values from a fixed-seed shift register
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic             clk_i = 1'b0, resetn_i = 1'b0, por_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, wk;
  logic [1:0]       htrans_i = 2'h0;
  logic [31:0]      haddr_i = 32'h0, hwdata_i = 32'h0, q, seed = 32'h3474;
  logic [7:0]       ext_en = 8'hFF, ext_val = 8'h00, a;
  logic [7:0]       ra [6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h30};
  logic [7:0]       rv [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
  int               fail_count = 0, comparisons = 0, cycles = 0;
  wire logic        hready, flag, wake_o;
  wire logic [31:0] hrdata_o;
  wire logic [7:0]  pin_o, pin_oe_o, pullup_on_o, level;
  port_pin_pullup_change_detect dut (.clk_i(clk_i), .resetn_i(resetn_i), .por_n_i(por_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hready), .hrdata_o(hrdata_o), .hreadyout_o(hready), .hresp_o(), .pin_i(level), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pullup_on_o(pullup_on_o), .port_change_flag_o(flag), .wake_o(wake_o));
  pin_partner far (.clk_i(clk_i), .drive_i(pin_o), .oe_i(pin_oe_o), .pullup_i(pullup_on_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(level));
  initial
    forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s); return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
  function automatic logic [31:0] pexp(input logic [7:0] d, p, input logic g, m);
    return {24'h0, (g ? 8'h00 : p & d & 8'hF7) | {4'h0, m, 3'h0}};
  endfunction
  function automatic logic [31:0] rexp(input logic [7:0] d, v, e, a);
    return {24'h0, ((~d & v) | (d & e)) & ~a};
  endfunction
  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rst(input logic p);
    resetn_i <= 1'b0;
    por_n_i <= ~p;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    por_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, ad};
    hwrite_i <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d); bus(1'b1, ad, {24'h0, d}); endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(q, e);
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    rst(1'b1);
    for (int i = 0; i < 6; i++)
      rd(ra[i], {24'h0, rv[i]});
    chk(pullup_on_o, 32'h08);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      a = (i == 0) ? 8'hFF : seed[31:24];
      wr(8'h14, {i[0], 7'h0});
      wr(8'h08, seed[7:0]);
      wr(8'h10, seed[15:8]);
      wr(8'h20, {7'h0, i[1]});
      wr(8'h0C, a);
      wr(8'h00, seed[23:16]);
      ext_en <= seed[7:0];
      ext_val <= seed[31:24] ^ seed[15:8];
      repeat (4) @(posedge clk_i);
      chk(pullup_on_o, pexp(seed[7:0], seed[15:8], i[0], i[1]));
      chk(pin_oe_o, {24'h0, ~seed[7:0]});
      chk(pin_o, seed[23:16]);
      rd(8'h00, rexp(seed[7:0], seed[23:16], seed[31:24] ^ seed[15:8], a));
    end
    wr(8'h08, 8'hFF);
    wr(8'h0C, 8'h00);
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    wr(8'h18, 8'h20);
    repeat (4) @(posedge clk_i);
    rd(8'h00, 32'h0);
    wr(8'h1C, 8'h00);
    wr(8'h20, 8'h02);
    ext_val <= 8'h01;
    repeat (6) @(posedge clk_i);
    chk(flag, 32'h0);
    ext_val <= 8'h21;
    wk = 1'b0;
    repeat (8) @(posedge clk_i) wk = wk | wake_o;
    chk(wk, 32'h1);
    chk(flag, 32'h1);
    wr(8'h1C, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(flag, 32'h1);
    rst(1'b0);
    wr(8'h0C, 8'h00);
    repeat (6) @(posedge clk_i);
    chk(flag, 32'h1);
    rd(8'h18, 32'h20);
    rd(8'h00, 32'h21);
    wr(8'h1C, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(flag, 32'h0);
    rst(1'b1);
    rd(8'h18, 32'h0);
    wr(8'h1C, 8'h01);
    rd(8'h1C, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
